// File: cplc_analog_model.sv
// behavioural analog side: level codes and pump stroke count
`timescale 1ns/100ps
module cplc_analog_model (
  input wire pump_clk,
  output logic [5:0] gain_code,
  output logic [5:0] dac_env
);
  int rises = 0;
  initial gain_code = 6'h00;
  initial dac_env = 6'h00;
  // stroke count lets the bench judge divider rate without a period probe
  always @(posedge pump_clk) rises <= rises + 1;
endmodule

// File: cplc_clk_div.v
// pump clock divider: divide by 8 << sel, held at 256 for sel 5 to 7, stopped when not running
`timescale 1ns/100ps
`include "cplc_defs.vh"
module cplc_clk_div (
  clk,
  rst_b,
  ce,
  run,
  sel,
  pump_clk
);
  input wire clk;
  input wire rst_b;
  input wire ce;
  input wire run;
  input wire [2:0] sel;
  output reg pump_clk;
  reg [6:0] cnt_q;
  wire [6:0] half_w;
  // half period is 4 << sel cycles of the core clock, held at 128 for sel 5 to 7
  assign half_w = 7'h04 << sel;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 7'h00;
      pump_clk <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        cnt_q <= 7'h00;
        pump_clk <= 1'b0;
      end else if (cnt_q >= half_w - 7'h01) begin
        cnt_q <= 7'h00;
        pump_clk <= ~pump_clk;
      end else begin
        cnt_q <= cnt_q + 7'h01;
      end
    end
  end
endmodule

// File: cplc_defs.vh
// constants for the charge pump level controller
`ifndef CPLC_DEFS_VH
`define CPLC_DEFS_VH
`define CPLC_ADDR_CTRL 12'h000
`define CPLC_ADDR_THRESH 12'h004
`define CPLC_ADDR_HOLD 12'h008
`define CPLC_ADDR_STATUS 12'h00C
`define CPLC_CTRL_EN_BIT 0
`define CPLC_CTRL_MODE_LSB 1
`define CPLC_CTRL_LEVEL_LSB 4
`define CPLC_CTRL_FLOOR_LSB 8
`define CPLC_CTRL_RESET 32'h0000_0100
`define CPLC_THRESH_RESET 6'h10
`define CPLC_HOLD_RESET 16'h0010
`define CPLC_MODE_MANUAL 2'h0
`define CPLC_MODE_GAIN 2'h1
`define CPLC_MODE_DAC 2'h2
`define CPLC_MODE_OUT 2'h3
`define CPLC_HOLD_UNIT_US 1000
`define CPLC_CLK_MHZ 40
`define CPLC_HOLD_UNIT_CYC (`CPLC_HOLD_UNIT_US * `CPLC_CLK_MHZ)
`define CPLC_DIV_MAX_SEL 3'h0
`define CPLC_DIV_FREE_SEL 3'h5
`endif

// File: cplc_props.sv
// port-level assertions for the charge pump level controller
`timescale 1ns/100ps
`include "cplc_defs.vh"
module cplc_props #(parameter LW = 3) (
  input wire clk,
  input wire rst_b,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire [LW-1:0] pump_level,
  input wire half_rail_sel,
  input wire pump_clk,
  input wire pump_run
);
  logic [31:0] ctrl_q;
  // shadow of the control word, seen only through the bus
  always @(posedge clk or negedge rst_b)
    if (!rst_b) ctrl_q <= `CPLC_CTRL_RESET;
    else if (ce && psel && penable && pwrite && paddr == `CPLC_ADDR_CTRL) ctrl_q <= pwdata;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_hole;
    s_acc ##0 paddr[11:4] != 8'h00;
  endsequence
  a_pready_high: assert property (pready) else $error("pready low");
  a_hole_err: assert property (s_hole |-> pslverr) else $error("hole not refused");
  a_run_follows: assert property (ce |=> pump_run == $past(ctrl_q[0]))
    else $error("run not following enable");
  a_clk_stopped: assert property (!pump_run && !$past(pump_run) |-> !pump_clk)
    else $error("pump clock while off");
  a_idle_full: assert property (!pump_run && !$past(pump_run) |-> !half_rail_sel)
    else $error("rail moved while off");
  // no tracking demand may push the divider past its /8 ceiling
  a_clk_ceiling: assert property ($rose(pump_clk) |=> ($stable(pump_clk) || !pump_run)[*3])
    else $error("pump clock above ceiling");
  // hold may delay a drop, so only the lower bound is firm
  a_manual_raise: assert property (pump_run && $past(ce) && ctrl_q[2:1] == `CPLC_MODE_MANUAL
    && $stable(ctrl_q) |-> pump_level >= ctrl_q[6:4]) else $error("manual level low");
  a_low_modes_full: assert property (ce && $past(ce) && !ctrl_q[2] && !$past(ctrl_q[2])
    |-> !half_rail_sel) else $error("half rail in low mode");
endmodule

// File: cplc_top.v
// charge pump level controller with apb register access
//
// Overview of operation
// - pump runs only while enable bit set
// - mode 00: level comes from manual field
// - mode 01: level tracks programmed gain
// - mode 10: level tracks dac envelope
// - mode 11: level combines gain and signal
// - modes 10/11 pick full or half rail
// - rail changeover compares envelope or signal size to threshold
// - dac mode threshold codes; reserved codes avoided
// - output mode codes 02-0B set changeover
// - output mode codes 00-01 force full rail
// - output mode codes 0C-0F force half rail
// - gain mode raises pump clock on demand
// - signal modes raise pump clock on demand
// - floor divider setting; tracking ceiling is /8
// - hold before lowering; raise immediately
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/100ps
`include "cplc_defs.vh"
module cplc_top #(
  parameter LW = 3,
  parameter HOLD_UNIT_CYC = `CPLC_HOLD_UNIT_CYC
) (
  clk,
  rst_b,
  ce,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  gain_code,
  dac_env,
  pump_level,
  half_rail_sel,
  pump_clk,
  pump_run
);
  input wire clk;
  input wire rst_b;
  input wire ce;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [11:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output wire pready;
  output wire pslverr;
  input wire [5:0] gain_code;
  input wire [5:0] dac_env;
  output reg [LW-1:0] pump_level;
  output reg half_rail_sel;
  output wire pump_clk;
  output reg pump_run;

  reg pump_on_q;
  reg [1:0] mode_q;
  reg [LW-1:0] manual_level_q;
  reg [2:0] floor_q;
  reg [5:0] thresh_q;
  reg [15:0] hold_q;
  reg [5:0] gain_s1_q, gain_s2_q, env_s1_q, env_s2_q;
  reg [LW-1:0] need_d;
  reg half_d;
  reg [2:0] div_d;
  reg [15:0] hold_cnt_q;
  reg [31:0] tick_q;
  reg [31:0] rdata_d;
  wire wr_w;
  wire rd_w;
  wire hit_w;
  wire [5:0] sig_w;

  // single-cycle access phase, unmapped addresses return error
  assign pready = 1'b1;
  assign hit_w = (paddr == `CPLC_ADDR_CTRL) || (paddr == `CPLC_ADDR_THRESH) ||
                 (paddr == `CPLC_ADDR_HOLD) || (paddr == `CPLC_ADDR_STATUS);
  assign pslverr = psel & penable & ~hit_w;
  assign wr_w = psel & penable & pwrite & hit_w;
  assign rd_w = psel & penable & ~pwrite & hit_w;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pump_on_q <= 1'b0;
      mode_q <= `CPLC_MODE_MANUAL;
      manual_level_q <= {LW{1'b0}};
      floor_q <= 3'h1;
      thresh_q <= `CPLC_THRESH_RESET;
      hold_q <= `CPLC_HOLD_RESET;
    end else if (ce && wr_w) begin
      case (paddr)
        `CPLC_ADDR_CTRL: begin
          pump_on_q <= pwdata[`CPLC_CTRL_EN_BIT];
          mode_q <= pwdata[`CPLC_CTRL_MODE_LSB +: 2];
          manual_level_q <= pwdata[`CPLC_CTRL_LEVEL_LSB +: LW];
          floor_q <= pwdata[`CPLC_CTRL_FLOOR_LSB +: 3];
        end
        `CPLC_ADDR_THRESH: thresh_q <= pwdata[5:0];
        `CPLC_ADDR_HOLD: hold_q <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  always @* begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      `CPLC_ADDR_CTRL: begin
        rdata_d[`CPLC_CTRL_EN_BIT] = pump_on_q;
        rdata_d[`CPLC_CTRL_MODE_LSB +: 2] = mode_q;
        rdata_d[`CPLC_CTRL_LEVEL_LSB +: LW] = manual_level_q;
        rdata_d[`CPLC_CTRL_FLOOR_LSB +: 3] = floor_q;
      end
      `CPLC_ADDR_THRESH: rdata_d[5:0] = thresh_q;
      `CPLC_ADDR_HOLD: rdata_d[15:0] = hold_q;
      `CPLC_ADDR_STATUS: begin
        rdata_d[LW-1:0] = pump_level;
        rdata_d[8] = half_rail_sel;
        rdata_d[9] = pump_run;
        rdata_d[12:10] = div_d;
      end
      default: ;
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) prdata <= 32'h0000_0000;
    else if (ce && rd_w) prdata <= rdata_d;
  end

  // analog-side levels arrive from another domain: two flops each
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gain_s1_q <= 6'h00;
      gain_s2_q <= 6'h00;
      env_s1_q <= 6'h00;
      env_s2_q <= 6'h00;
    end else if (ce) begin
      gain_s1_q <= gain_code;
      gain_s2_q <= gain_s1_q;
      env_s1_q <= dac_env;
      env_s2_q <= env_s1_q;
    end
  end

  // gain-scaled signal size: envelope capped by the gain setting
  assign sig_w = (env_s2_q < gain_s2_q) ? env_s2_q : gain_s2_q;

  always @* begin
    need_d = manual_level_q;
    half_d = 1'b0;
    case (mode_q)
      `CPLC_MODE_MANUAL: need_d = manual_level_q;
      `CPLC_MODE_GAIN: need_d = gain_s2_q[5:6-LW];
      `CPLC_MODE_DAC: begin
        need_d = env_s2_q[5:6-LW];
        half_d = (env_s2_q < thresh_q);
      end
      `CPLC_MODE_OUT: begin
        need_d = sig_w[5:6-LW];
        if (thresh_q < 6'h02) half_d = 1'b0;
        else if (thresh_q >= 6'h0C) half_d = 1'b1;
        else half_d = ({sig_w[5:2]} < thresh_q[3:0]);
      end
      default: need_d = manual_level_q;
    endcase
    // in tracking modes higher demand shortens the divider, floor setting (above 4 taken as 4) as the slowest
    if (mode_q == `CPLC_MODE_MANUAL) div_d = floor_q;
    else if (need_d[LW-1]) div_d = `CPLC_DIV_MAX_SEL;
    else if (floor_q == `CPLC_DIV_FREE_SEL || floor_q > 3'h4) div_d = 3'h4;
    else div_d = floor_q;
  end

  // level rises at once; it falls only after a full hold period
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pump_level <= {LW{1'b0}};
      half_rail_sel <= 1'b0;
      pump_run <= 1'b0;
      hold_cnt_q <= 16'h0000;
      tick_q <= 32'h0000_0000;
    end else if (ce) begin
      pump_run <= pump_on_q;
      if (!pump_on_q) begin
        pump_level <= {LW{1'b0}};
        half_rail_sel <= 1'b0;
        hold_cnt_q <= 16'h0000;
        tick_q <= 32'h0000_0000;
      end else begin
        half_rail_sel <= half_d;
        if (need_d >= pump_level) begin
          pump_level <= need_d;
          hold_cnt_q <= 16'h0000;
          tick_q <= 32'h0000_0000;
        end else if (hold_cnt_q >= hold_q) begin
          pump_level <= need_d;
          hold_cnt_q <= 16'h0000;
        end else if (tick_q >= HOLD_UNIT_CYC - 1) begin
          tick_q <= 32'h0000_0000;
          hold_cnt_q <= hold_cnt_q + 16'h0001;
        end else begin
          tick_q <= tick_q + 32'h0000_0001;
        end
      end
    end
  end

  cplc_clk_div u_div (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .run(pump_run),
    .sel(div_d),
    .pump_clk(pump_clk)
  );
endmodule

// File: tb_top.sv
// self-checking bench for the charge pump level controller
`timescale 1ns/100ps
`include "cplc_defs.vh"
module tb_top;
  logic clk = 0, rst_b = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, half_rail_sel, pump_clk, pump_run;
  logic [5:0] gain_code, dac_env;
  logic [2:0] pump_level;
  int errors = 0, tests_run = 0, r0;
  cplc_top #(.HOLD_UNIT_CYC(4)) dut_u (.*);
  cplc_analog_model m (.*);
  initial forever #12.5 clk = ~clk;
  task ck(input logic ok, input string s);
    tests_run++;
    if (ok !== 1'b1) begin
      errors++;
      $display("MISMATCH %0t %s", $time, s);
    end
  endtask
  task end_of_test;
    if (errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 16) begin
      errors++;
      end_of_test;
    end
    // read data is registered at the taking edge; it stands from the next edge on
    @(posedge clk);
    rd = prdata;
  endtask
  task cw(input logic [1:0] md, input logic [2:0] lv, input logic [2:0] fl, input logic en);
    apb(1, `CPLC_ADDR_CTRL, {21'h0, fl, 1'b0, lv, 1'b0, md, en});
  endtask
  task stim(input logic [5:0] g, input logic [5:0] e);
    @(posedge clk);
    m.gain_code <= g;
    m.dac_env <= e;
  endtask
  task t_regs;
    apb(0, `CPLC_ADDR_CTRL, 0);
    ck(rd === `CPLC_CTRL_RESET, "ctrl reset");
    apb(1, 12'h010, 32'hFFFF_FFFF);
    ck(er === 1'b1, "hole");
  endtask
  task t_off;
    cw(`CPLC_MODE_DAC, 3'h0, 3'h0, 0);
    stim(6'h00, 6'h00);
    r0 = m.rises;
    wt(300);
    ck(m.rises == r0 && half_rail_sel === 1'b0 && pump_run === 1'b0, "idle");
  endtask
  task t_manual;
    for (int i = 0; i < 8; i++) begin
      cw(`CPLC_MODE_MANUAL, i[2:0], 3'h0, 1);
      wt(3);
      ck(pump_level === i[2:0] && pump_run === 1'b1, "manual");
    end
    r0 = m.rises;
    wt(256);
    ck(m.rises - r0 == 32, "div 8");
    cw(`CPLC_MODE_MANUAL, 3'h7, 3'h4, 1);
    wt(130);
    r0 = m.rises;
    wt(256);
    ck(m.rises - r0 == 2, "div 128");
  endtask
  task t_track(input logic [1:0] md, input logic [5:0] g, input logic [5:0] e);
    cw(md, 3'h0, 3'h4, 1);
    stim(g, e);
    wt(6);
    ck(pump_level === 3'h7 && half_rail_sel === 1'b0, "track high");
    r0 = m.rises;
    wt(256);
    ck(m.rises - r0 > 2, "boost");
  endtask
  task t_dac_drop;
    stim(6'h00, 6'h01);
    wt(4);
    ck(pump_level === 3'h7, "held");
    wt(20);
    ck(pump_level === 3'h0 && half_rail_sel === 1'b1, "dac low");
  endtask
  task oc(input logic [5:0] th, input logic [5:0] s, input logic x);
    apb(1, `CPLC_ADDR_THRESH, {26'h0, th});
    stim(s, s);
    wt(24);
    ck(half_rail_sel === x, "out rail");
  endtask
  task t_out;
    cw(`CPLC_MODE_OUT, 3'h0, 3'h4, 1);
    oc(6'h06, 6'h00, 1);
    oc(6'h06, 6'h3F, 0);
    oc(6'h0F, 6'h3F, 1);
    oc(6'h00, 6'h00, 0);
  endtask
  task t_ce;
    apb(0, `CPLC_ADDR_STATUS, 0);
    ck(rd === 32'h0000_1200, "status");
    @(posedge clk);
    ce <= 0;
    r0 = m.rises;
    cw(`CPLC_MODE_MANUAL, 3'h7, 3'h0, 0);
    wt(50);
    ck(m.rises == r0 && pump_run === 1'b1 && pump_level === 3'h0, "freeze");
    @(posedge clk);
    ce <= 1;
    apb(0, `CPLC_ADDR_CTRL, 0);
    ck(rd === 32'h0000_0407, "ctrl kept");
  endtask
  initial begin
    wt(8);
    rst_b <= 1;
    t_regs;
    t_off;
    t_manual;
    t_track(`CPLC_MODE_GAIN, 6'h3F, 6'h00);
    apb(1, `CPLC_ADDR_HOLD, 32'h2);
    apb(1, `CPLC_ADDR_THRESH, 32'h10);
    t_track(`CPLC_MODE_DAC, 6'h00, 6'h3F);
    t_dac_drop;
    t_out;
    t_ce;
    end_of_test;
  end
endmodule
bind cplc_top cplc_props #(.LW(LW)) p_u (.*);
